// ---- rtl/ufc_core.sv ----
// Serial transceiver core with handshake lines, APB slave
//
// Added by the designer: the address map and register access over APB.
`timescale 1ns/10ps
module ufc_core #(
	parameter int BIT_CYCLES = ufc_pkg::BIT_CYCLES,
	parameter int FIFO_DEPTH = ufc_pkg::FIFO_DEPTH,
	parameter int RTS_ROOM = ufc_pkg::RTS_ROOM,
	parameter int RECEIVER_TIMEOUT_EVENT_FRAMES = ufc_pkg::RECEIVER_TIMEOUT_EVENT_FRAMES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxd_in,
	input wire logic cts_n_in,
	output logic txd_out,
	output logic rts_n_out
);
	localparam int PW = $clog2(FIFO_DEPTH);
	localparam logic [PW:0] RTS_FILL = (PW + 1)'(FIFO_DEPTH - RTS_ROOM);

	generate
		if (FIFO_DEPTH <= RTS_ROOM || BIT_CYCLES < 4) begin : g_bad
			$error("ufc_core: unusable parameters");
		end
	endgenerate

	// Parity over a byte, odd sense when asked
	function automatic logic par_of(input logic [7:0] b, input logic odd);
		par_of = ^b ^ odd;
	endfunction

	// ==========================================
	// APB access
	logic wr, rd, en, flow, par_en, par_odd, tx_run, rx_run, txd_full, rxd_valid, rts_on, move;
	logic ev_rxrdy, ev_txrdy, ev_error, ev_receiver_timeout_event, tx_done, push, receiver_timeout_event_hit;
	logic [3:0] errsrc, err_set;
	logic [15:0] baud;
	logic [7:0] tx_hold, rx_hold, rx_byte;
	logic [31:0] pin_sel [4];
	logic [31:0] next_prdata;
	logic next_slverr;
	logic [PW:0] fifo_count;
	assign wr = psel & penable & pready & pwrite;
	assign rd = psel & penable & pready & ~pwrite;
	wire begin_receive_task = wr && paddr == ufc_pkg::OFF_BEGIN_RX && pwdata[0];
	wire halt_receive_task = wr && paddr == ufc_pkg::OFF_HALT_RX && pwdata[0];
	wire begin_transmit_task = wr && paddr == ufc_pkg::OFF_BEGIN_TX && pwdata[0];
	wire halt_transmit_task = wr && paddr == ufc_pkg::OFF_HALT_TX && pwdata[0];
	wire suspend_task = wr && paddr == ufc_pkg::OFF_SUSPEND && pwdata[0];

	// Zero-wait answer in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable & ~pready;
			prdata <= next_prdata;
			pslverr <= next_slverr;
		end
	end

	// Read mux; unmapped answers with an error
	always_comb begin
		next_prdata = 32'h00000000;
		next_slverr = 1'b0;
		unique case (paddr)
			ufc_pkg::OFF_BEGIN_RX, ufc_pkg::OFF_HALT_RX, ufc_pkg::OFF_BEGIN_TX,
			ufc_pkg::OFF_HALT_TX, ufc_pkg::OFF_SUSPEND: next_prdata = 32'h00000000;
			ufc_pkg::OFF_EV_RXRDY: next_prdata = {31'h0, ev_rxrdy};
			ufc_pkg::OFF_EV_TXRDY: next_prdata = {31'h0, ev_txrdy};
			ufc_pkg::OFF_EV_ERROR: next_prdata = {31'h0, ev_error};
			ufc_pkg::OFF_EV_RECEIVER_TIMEOUT_EVENT: next_prdata = {31'h0, ev_receiver_timeout_event};
			ufc_pkg::OFF_ERRSRC: next_prdata = {28'h0, errsrc};
			ufc_pkg::OFF_ENABLE: next_prdata = {31'h0, en};
			ufc_pkg::OFF_PIN_RTS: next_prdata = pin_sel[0];
			ufc_pkg::OFF_PIN_TXD: next_prdata = pin_sel[1];
			ufc_pkg::OFF_PIN_CTS: next_prdata = pin_sel[2];
			ufc_pkg::OFF_PIN_RXD: next_prdata = pin_sel[3];
			ufc_pkg::OFF_RX_HOLD: next_prdata = {24'h0, rx_hold};
			ufc_pkg::OFF_TX_HOLD: next_prdata = {24'h0, tx_hold};
			ufc_pkg::OFF_BAUD: next_prdata = {16'h0, baud};
			ufc_pkg::OFF_CONFIG: next_prdata = {29'h0, par_odd, par_en, flow};
			default: next_slverr = psel & ~penable;
		endcase
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en <= 1'b0;
			flow <= 1'b0;
			par_en <= 1'b0;
			par_odd <= 1'b0;
			baud <= 16'(BIT_CYCLES);
			for (int i = 0; i < 4; i++) pin_sel[i] <= ufc_pkg::PIN_RESET;
		end else if (wr) begin
			if (paddr == ufc_pkg::OFF_ENABLE) en <= pwdata[0];
			if (paddr == ufc_pkg::OFF_BAUD && pwdata[15:0] > 16'h0003) baud <= pwdata[15:0];
			if (paddr == ufc_pkg::OFF_CONFIG) begin
				flow <= pwdata[ufc_pkg::CFG_FLOW_BIT];
				par_en <= pwdata[ufc_pkg::CFG_PAR_BIT];
				par_odd <= pwdata[ufc_pkg::CFG_ODD_BIT];
			end
			if (paddr == ufc_pkg::OFF_PIN_RTS) pin_sel[0] <= pwdata;
			if (paddr == ufc_pkg::OFF_PIN_TXD) pin_sel[1] <= pwdata;
			if (paddr == ufc_pkg::OFF_PIN_CTS) pin_sel[2] <= pwdata;
			if (paddr == ufc_pkg::OFF_PIN_RXD) pin_sel[3] <= pwdata;
		end
	end

	// Sticky events: hardware set wins over a software write of zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_rxrdy <= 1'b0;
			ev_txrdy <= 1'b0;
			ev_error <= 1'b0;
			ev_receiver_timeout_event <= 1'b0;
			errsrc <= 4'h0;
		end else begin
			ev_rxrdy <= move | (ev_rxrdy & ~(wr && paddr == ufc_pkg::OFF_EV_RXRDY && !pwdata[0]));
			ev_txrdy <= tx_done | (ev_txrdy & ~(wr && paddr == ufc_pkg::OFF_EV_TXRDY && !pwdata[0]));
			ev_error <= (|err_set) | (ev_error & ~(wr && paddr == ufc_pkg::OFF_EV_ERROR && !pwdata[0]));
			ev_receiver_timeout_event <= receiver_timeout_event_hit | (ev_receiver_timeout_event & ~(wr && paddr == ufc_pkg::OFF_EV_RECEIVER_TIMEOUT_EVENT && !pwdata[0]));
			errsrc <= err_set | (errsrc & ~((wr && paddr == ufc_pkg::OFF_ERRSRC) ? pwdata[3:0] : 4'h0));
		end
	end

	// ==========================================
	// Pins
	wire rxd_eff = (en && !pin_sel[3][ufc_pkg::PIN_DISC_BIT]) ? rxd_in : 1'b1;
	wire cts_ok = !flow || (en && !pin_sel[2][ufc_pkg::PIN_DISC_BIT] && !cts_n_in);
	logic tx_line;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txd_out <= 1'b1;
			rts_n_out <= 1'b1;
		end else begin
			txd_out <= (en && !pin_sel[1][ufc_pkg::PIN_DISC_BIT]) ? tx_line : 1'b1;
			rts_n_out <= (en && !pin_sel[0][ufc_pkg::PIN_DISC_BIT]) ? !(rts_on || !flow) : 1'b1;
		end
	end

	// ==========================================
	// Transmitter
	ufc_pkg::ufc_tx_type tx_state;
	logic [10:0] tx_sh;
	logic [3:0] tx_bits;
	logic [15:0] tx_div;
	assign tx_done = tx_state == ufc_pkg::TX_SHIFT && tx_div == 16'h0001 && tx_bits == 4'h1;

	// Run flag: begin task sets, halt or suspend clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) tx_run <= 1'b0;
		else if (halt_transmit_task || suspend_task) tx_run <= 1'b0;
		else if (begin_transmit_task) tx_run <= 1'b1;
	end

	// Holding register full flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txd_full <= 1'b0;
			tx_hold <= 8'h00;
		end else if (wr && paddr == ufc_pkg::OFF_TX_HOLD) begin
			txd_full <= 1'b1;
			tx_hold <= pwdata[7:0];
		end else if (tx_state == ufc_pkg::TX_IDLE && tx_run && txd_full && cts_ok && en
			&& !halt_transmit_task) begin
			txd_full <= 1'b0; // Same condition as shifter launch, so no byte is lost
		end
	end

	// Shifter; CTS checked only between frames so a byte completes unless halted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_state <= ufc_pkg::TX_IDLE;
			tx_sh <= 11'h7ff;
			tx_bits <= 4'h0;
			tx_div <= 16'h0000;
			tx_line <= 1'b1;
		end else if (halt_transmit_task) begin
			tx_state <= ufc_pkg::TX_IDLE;
			tx_line <= 1'b1;
		end else unique case (tx_state)
			ufc_pkg::TX_IDLE: begin
				tx_line <= 1'b1;
				if (tx_run && txd_full && cts_ok && en) begin
					tx_state <= ufc_pkg::TX_SHIFT;
					tx_sh <= par_en ? {1'b1, par_of(tx_hold, par_odd), tx_hold, 1'b0}
						: {2'b11, tx_hold, 1'b0};
					tx_bits <= par_en ? 4'(ufc_pkg::FRAME_BITS + 1) : 4'(ufc_pkg::FRAME_BITS);
					tx_div <= 16'h0000;
				end
			end
			ufc_pkg::TX_SHIFT: begin
				if (tx_div <= 16'h0001) begin
					if (tx_div == 16'h0001 && tx_bits == 4'h1) begin
						tx_state <= ufc_pkg::TX_IDLE;
						tx_line <= 1'b1;
					end else begin
						tx_line <= tx_sh[0];
						tx_sh <= {1'b1, tx_sh[10:1]};
						tx_div <= baud;
						if (tx_div == 16'h0001) tx_bits <= tx_bits - 4'h1;
					end
				end else tx_div <= tx_div - 16'h0001;
			end
			default: tx_state <= ufc_pkg::TX_IDLE;
		endcase
	end

	// ==========================================
	// Receiver
	ufc_pkg::ufc_rx_type rx_state;
	logic [31:0] receiver_timeout_event_cnt, rx_div;
	logic [3:0] rx_bits;
	logic [8:0] rx_sh;
	wire listen = rx_run || receiver_timeout_event_cnt != 32'h0;
	wire [3:0] rx_need = par_en ? 4'(ufc_pkg::DATA_BITS + 1) : 4'(ufc_pkg::DATA_BITS);
	assign receiver_timeout_event_hit = !rx_run && receiver_timeout_event_cnt == 32'h1;

	// Run flag and extended window after halt or suspend
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_run <= 1'b0;
			receiver_timeout_event_cnt <= 32'h0;
		end else if (halt_receive_task || suspend_task) begin
			rx_run <= 1'b0;
			if (rx_run) receiver_timeout_event_cnt <= 32'(baud) * 32'(ufc_pkg::FRAME_BITS + 1) * 32'(RECEIVER_TIMEOUT_EVENT_FRAMES);
		end else if (begin_receive_task) begin
			rx_run <= 1'b1;
			receiver_timeout_event_cnt <= 32'h0;
		end else if (receiver_timeout_event_cnt != 32'h0) receiver_timeout_event_cnt <= receiver_timeout_event_cnt - 32'h1;
	end

	// Frame sampler with framing and break detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state <= ufc_pkg::RX_IDLE;
			rx_div <= 32'h0;
			rx_bits <= 4'h0;
			rx_sh <= 9'h000;
		end else begin
			if (rx_div != 32'h0) rx_div <= rx_div - 32'h1;
			unique case (rx_state)
				ufc_pkg::RX_IDLE: if (listen && en && !rxd_eff) begin
					rx_state <= ufc_pkg::RX_START;
					rx_div <= 32'(baud >> 1);
				end
				ufc_pkg::RX_START: if (rx_div == 32'h0) begin
					rx_state <= rxd_eff ? ufc_pkg::RX_IDLE : ufc_pkg::RX_DATA;
					rx_div <= 32'(baud) - 32'h1; // Zero cycle ends the bit
					rx_bits <= 4'h0;
				end
				ufc_pkg::RX_DATA: if (rx_div == 32'h0) begin
					rx_sh <= par_en ? {rxd_eff, rx_sh[8:1]} : {1'b0, rxd_eff, rx_sh[7:1]};
					rx_bits <= rx_bits + 4'h1;
					rx_div <= 32'(baud) - 32'h1; // Keeps sampling at bit centres
					if (rx_bits + 4'h1 == rx_need) rx_state <= ufc_pkg::RX_STOP;
				end
				ufc_pkg::RX_STOP: if (rx_div == 32'h0) begin
					rx_state <= rxd_eff ? ufc_pkg::RX_IDLE : ufc_pkg::RX_BREAK;
					rx_div <= 32'(baud) * 32'(ufc_pkg::FRAME_BITS + 1);
				end
				ufc_pkg::RX_BREAK: if (rxd_eff) rx_state <= ufc_pkg::RX_IDLE;
					else if (rx_div == 32'h0) rx_state <= ufc_pkg::RX_HOLD;
				ufc_pkg::RX_HOLD: if (rxd_eff) rx_state <= ufc_pkg::RX_IDLE;
				default: rx_state <= ufc_pkg::RX_IDLE;
			endcase
		end
	end

	// Byte, parity and error strobes from the sampler
	assign rx_byte = rx_sh[7:0];
	assign push = rx_state == ufc_pkg::RX_STOP && rx_div == 32'h0 && rxd_eff;
	assign err_set[ufc_pkg::ERR_FRAMING_BIT] = rx_state == ufc_pkg::RX_STOP && rx_div == 32'h0 && !rxd_eff;
	assign err_set[ufc_pkg::ERR_BREAK_BIT] = rx_state == ufc_pkg::RX_BREAK && !rxd_eff && rx_div == 32'h0;
	assign err_set[ufc_pkg::ERR_PARITY_BIT] = push && par_en && (par_of(rx_sh[7:0], par_odd) != rx_sh[8]);
	assign err_set[ufc_pkg::ERR_OVERRUN_BIT] = push && !move && fifo_count == (PW + 1)'(FIFO_DEPTH);

	// ==========================================
	// Receive FIFO and holding register
	logic [7:0] fifo_mem [FIFO_DEPTH];
	logic [PW-1:0] wr_ptr, rd_ptr;
	wire full_drop = err_set[ufc_pkg::ERR_OVERRUN_BIT];
	assign move = !rxd_valid && fifo_count != '0;
	function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
		ptr_inc = (p == (PW)'(FIFO_DEPTH - 1)) ? '0 : p + (PW)'(1);
	endfunction

	// Full FIFO drops its oldest entry so the receiver never stalls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fifo_count <= '0;
		end else begin
			if (push) wr_ptr <= ptr_inc(wr_ptr);
			if (move || full_drop) rd_ptr <= ptr_inc(rd_ptr);
			if (push && !move && !full_drop) fifo_count <= fifo_count + 1'b1;
			else if (move && !push) fifo_count <= fifo_count - 1'b1;
		end
	end

	// Storage array
	always_ff @(posedge pclk) begin
		if (push) fifo_mem[wr_ptr] <= rx_byte;
	end

	// Holding register loads whenever it is empty
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxd_valid <= 1'b0;
			rx_hold <= 8'h00;
		end else if (move) begin
			rxd_valid <= 1'b1;
			rx_hold <= fifo_mem[rd_ptr];
		end else if (rd && paddr == ufc_pkg::OFF_RX_HOLD) rxd_valid <= 1'b0;
	end

	// RTS: off when room shrinks to four or receiver halts, on only when empty
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) rts_on <= 1'b0;
		else if (!rx_run || halt_receive_task || suspend_task) rts_on <= 1'b0;
		else if (fifo_count >= RTS_FILL) rts_on <= 1'b0;
		else if (fifo_count == '0) rts_on <= 1'b1;
	end

	// ==========================================
	// Checks
	wire tx_busy = tx_state != ufc_pkg::TX_IDLE;
	property p_tx_start; @(posedge pclk) disable iff (!presetn)
		$rose(tx_busy) |-> $past(tx_run) && $past(txd_full); endproperty
	a_tx_start: assert property (p_tx_start) else $error("tx frame without run");
	property p_tx_halt; @(posedge pclk) disable iff (!presetn)
		halt_transmit_task |=> !tx_busy ##1 txd_out; endproperty
	a_tx_halt: assert property (p_tx_halt) else $error("tx not halted");
	property p_tx_event; @(posedge pclk) disable iff (!presetn)
		$rose(ev_txrdy) |-> $past(tx_busy) && !tx_busy; endproperty
	a_tx_event: assert property (p_tx_event) else $error("tx ready off frame end");
	property p_tx_cts; @(posedge pclk) disable iff (!presetn)
		$rose(tx_busy) && flow |-> $past(cts_ok); endproperty
	a_tx_cts: assert property (p_tx_cts) else $error("frame started with CTS off");
	property p_tx_susp; @(posedge pclk) disable iff (!presetn)
		suspend_task && tx_busy && !tx_done && !halt_transmit_task |=> tx_busy; endproperty
	a_tx_susp: assert property (p_tx_susp) else $error("suspend cut frame");
	property p_fifo_cap; @(posedge pclk) disable iff (!presetn)
		push && fifo_count == (PW + 1)'(FIFO_DEPTH) && !move |=> fifo_count == $past(fifo_count); endproperty
	a_fifo_cap: assert property (p_fifo_cap) else $error("fifo overflow count");
	property p_rx_move; @(posedge pclk) disable iff (!presetn)
		move |=> rxd_valid && ev_rxrdy; endproperty
	a_rx_move: assert property (p_rx_move) else $error("move without event");
	property p_rts_off; @(posedge pclk) disable iff (!presetn)
		fifo_count >= RTS_FILL |=> !rts_on ##1 (rts_n_out || !flow || !en); endproperty
	a_rts_off: assert property (p_rts_off) else $error("RTS still on");
	property p_rts_on; @(posedge pclk) disable iff (!presetn)
		$rose(rts_on) |-> $past(fifo_count) == '0; endproperty
	a_rts_on: assert property (p_rts_on) else $error("RTS on with data");
	property p_rx_halt; @(posedge pclk) disable iff (!presetn)
		halt_receive_task || suspend_task |=> !rts_on && !rx_run; endproperty
	a_rx_halt: assert property (p_rx_halt) else $error("halt left RTS on");
	property p_receiver_timeout_event; @(posedge pclk) disable iff (!presetn)
		$rose(ev_receiver_timeout_event) |-> $past(receiver_timeout_event_cnt) == 32'h1 && !listen; endproperty
	a_receiver_timeout_event: assert property (p_receiver_timeout_event) else $error("timeout off window end");
	property p_break; @(posedge pclk) disable iff (!presetn)
		err_set[ufc_pkg::ERR_BREAK_BIT] |-> errsrc[ufc_pkg::ERR_FRAMING_BIT] || ev_error; endproperty
	a_break: assert property (p_break) else $error("break before framing");
	property p_pin_off; @(posedge pclk) disable iff (!presetn)
		!en |=> txd_out && rts_n_out; endproperty
	a_pin_off: assert property (p_pin_off) else $error("pin driven while off");
endmodule

// ---- rtl/ufc_pkg.sv ----
// Constants for the flow-controlled serial port core
package ufc_pkg;
	// ==========================================
	// Register byte offsets
	localparam logic [11:0] OFF_BEGIN_RX = 12'h000;
	localparam logic [11:0] OFF_HALT_RX = 12'h004;
	localparam logic [11:0] OFF_BEGIN_TX = 12'h008;
	localparam logic [11:0] OFF_HALT_TX = 12'h00c;
	localparam logic [11:0] OFF_SUSPEND = 12'h01c;
	localparam logic [11:0] OFF_EV_RXRDY = 12'h108;
	localparam logic [11:0] OFF_EV_TXRDY = 12'h11c;
	localparam logic [11:0] OFF_EV_ERROR = 12'h124;
	localparam logic [11:0] OFF_EV_RECEIVER_TIMEOUT_EVENT = 12'h144;
	localparam logic [11:0] OFF_ERRSRC = 12'h480;
	localparam logic [11:0] OFF_ENABLE = 12'h500;
	localparam logic [11:0] OFF_PIN_RTS = 12'h508;
	localparam logic [11:0] OFF_PIN_TXD = 12'h50c;
	localparam logic [11:0] OFF_PIN_CTS = 12'h510;
	localparam logic [11:0] OFF_PIN_RXD = 12'h514;
	localparam logic [11:0] OFF_RX_HOLD = 12'h518;
	localparam logic [11:0] OFF_TX_HOLD = 12'h51c;
	localparam logic [11:0] OFF_BAUD = 12'h524;
	localparam logic [11:0] OFF_CONFIG = 12'h56c;
	// ==========================================
	// Field positions and reset values
	localparam int PIN_DISC_BIT = 31;
	localparam logic [31:0] PIN_RESET = 32'hffffffff;
	localparam int CFG_FLOW_BIT = 0;
	localparam int CFG_PAR_BIT = 1;
	localparam int CFG_ODD_BIT = 2;
	localparam int ERR_OVERRUN_BIT = 0;
	localparam int ERR_PARITY_BIT = 1;
	localparam int ERR_FRAMING_BIT = 2;
	localparam int ERR_BREAK_BIT = 3;
	// ==========================================
	// Frame and buffer figures
	localparam int DATA_BITS = 8;
	localparam int FRAME_BITS = 10;
	localparam int FIFO_DEPTH = 6;
	localparam int RTS_ROOM = 4;
	localparam int RECEIVER_TIMEOUT_EVENT_FRAMES = 5;
	localparam int BIT_CYCLES = 868;
	typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} ufc_tx_type;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_BREAK, RX_HOLD} ufc_rx_type;
endpackage

// ---- tb/tb_top.sv ----
// Self-checking bench for the flow-controlled serial port core
`timescale 1ns/10ps
module tb_top;
	localparam int BIT = 8;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rxd_in;
	logic cts_n_in;
	logic txd_out;
	logic rts_n_out;
	logic [31:0] rdata;
	logic rerr;
	logic [7:0] b;
	logic [7:0] exp_q[$];
	logic [2:0] cfgs [3] = '{3'b011, 3'b111, 3'b001};
	int miscompares = 0;
	int checks_done = 0;
	int seed = 52820;
	// ==========================================
	// Clock, design and far side
	always #5 pclk = ~pclk;
	ufc_core #(.BIT_CYCLES(BIT)) i_ufc_core (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxd_in(rxd_in), .cts_n_in(cts_n_in),
		.txd_out(txd_out), .rts_n_out(rts_n_out));
	ufc_remote #(.BIT(BIT)) i_ufc_remote (.pclk(pclk), .txd_out(txd_out),
		.rts_n_out(rts_n_out), .rxd_in(rxd_in), .cts_n_in(cts_n_in));
	// ==========================================
	// Tasks
	task automatic complete_run();
		if (miscompares == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr_en, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// Poll an event flag, then clear it
	task automatic wait_ev(input logic [11:0] a);
		int n;
		n = 0;
		do begin
			rd(a);
			n++;
		end while (rdata[0] !== 1'b1 && n < 300);
		chk(rdata, 32'h1);
		wr(a, 32'h0);
	endtask
	task automatic rx_get();
		wait_ev(ufc_pkg::OFF_EV_RXRDY);
		rd(ufc_pkg::OFF_RX_HOLD);
		chk(rdata, {24'h0, exp_q.pop_front()});
	endtask
	// Model: one holding place plus six buffered, oldest buffered dropped
	task automatic rsend(input logic [7:0] v);
		if (exp_q.size() == 7) begin
			exp_q.delete(1);
		end
		exp_q.push_back(v);
		i_ufc_remote.send({1'b0, v}, 1'b1);
	endtask
	task automatic tx_check(input logic [8:0] e);
		wait_ev(ufc_pkg::OFF_EV_TXRDY);
		chk(32'(i_ufc_remote.got_q.size()), 32'h1);
		chk({23'h0, i_ufc_remote.got_q.pop_front()}, {23'h0, e});
	endtask
	task automatic tx_none();
		idle(15 * BIT);
		chk(32'(i_ufc_remote.got_q.size()), 32'h0);
	endtask
	// ==========================================
	// Watchdog
	initial begin
		#400000;
		miscompares++;
		complete_run();
	end
	// ==========================================
	// Main sequence
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(ufc_pkg::OFF_PIN_RTS);
		chk(rdata, ufc_pkg::PIN_RESET);
		rd(12'h7f0);
		chk({rdata[30:0], rerr}, 32'h1);
		// Disconnected pins keep the line quiet
		wr(ufc_pkg::OFF_ENABLE, 32'h1);
		wr(ufc_pkg::OFF_BEGIN_TX, 32'h1);
		wr(ufc_pkg::OFF_TX_HOLD, 32'h5a);
		idle(20 * BIT);
		chk(32'(i_ufc_remote.got_q.size()), 32'h0);
		wr(ufc_pkg::OFF_HALT_TX, 32'h1);
		wr(ufc_pkg::OFF_ENABLE, 32'h0);
		for (int i = 0; i < 4; i++) begin
			wr(ufc_pkg::OFF_PIN_RTS + 12'(4 * i), 32'h0);
		end
		wr(ufc_pkg::OFF_CONFIG, 32'h0);
		wr(ufc_pkg::OFF_ENABLE, 32'h1);
		wr(ufc_pkg::OFF_EV_TXRDY, 32'h0);
		// Receiver deaf until begun; then overfill without flow control
		i_ufc_remote.obey_rts = 1'b0;
		i_ufc_remote.send(9'h033, 1'b1);
		rd(ufc_pkg::OFF_EV_RXRDY);
		chk(rdata, 32'h0);
		wr(ufc_pkg::OFF_BEGIN_RX, 32'h1);
		for (int i = 0; i < 8; i++) begin
			rsend(8'($random(seed)));
		end
		chk({31'h0, rts_n_out}, 32'h0);
		for (int i = 0; i < 7; i++) begin
			rx_get();
		end
		rd(ufc_pkg::OFF_ERRSRC);
		chk(rdata, 32'h1);
		wr(ufc_pkg::OFF_ERRSRC, 32'hf);
		// Request-to-send follows the buffer fill
		wr(ufc_pkg::OFF_CONFIG, 32'h1);
		i_ufc_remote.obey_rts = 1'b1;
		for (int i = 0; i < 3; i++) begin
			rsend(8'($random(seed)));
		end
		idle(2);
		chk({31'h0, rts_n_out}, 32'h1);
		rx_get();
		chk({31'h0, rts_n_out}, 32'h1);
		rx_get();
		rx_get();
		chk({31'h0, rts_n_out}, 32'h0);
		// Transmit waits for its begin task; parity modes
		wr(ufc_pkg::OFF_TX_HOLD, 32'ha5);
		tx_none();
		wr(ufc_pkg::OFF_BEGIN_TX, 32'h1);
		tx_check(9'h0a5);
		for (int m = 0; m < 3; m++) begin
			b = 8'($random(seed));
			i_ufc_remote.nbits = cfgs[m][1] ? 9 : 8;
			wr(ufc_pkg::OFF_CONFIG, {29'h0, cfgs[m]});
			wr(ufc_pkg::OFF_TX_HOLD, {24'h0, b});
			tx_check({cfgs[m][1] & (^b ^ cfgs[m][2]), b});
		end
		// Clear-to-send: frame in flight finishes, next one waits
		b = 8'($random(seed));
		wr(ufc_pkg::OFF_TX_HOLD, {24'h0, b});
		idle(3 * BIT);
		i_ufc_remote.cts_n_in <= 1'b1;
		tx_check({1'b0, b});
		wr(ufc_pkg::OFF_TX_HOLD, 32'h96);
		tx_none();
		i_ufc_remote.cts_n_in <= 1'b0;
		tx_check(9'h096);
		// Suspend finishes the frame, then needs a restart
		b = 8'($random(seed));
		wr(ufc_pkg::OFF_TX_HOLD, {24'h0, b});
		idle(3 * BIT);
		wr(ufc_pkg::OFF_SUSPEND, 32'h1);
		tx_check({1'b0, b});
		wr(ufc_pkg::OFF_TX_HOLD, 32'h3c);
		tx_none();
		wr(ufc_pkg::OFF_BEGIN_TX, 32'h1);
		tx_check(9'h03c);
		// Halt drops the frame at once
		wr(ufc_pkg::OFF_TX_HOLD, 32'h00);
		idle(3 * BIT);
		wr(ufc_pkg::OFF_HALT_TX, 32'h1);
		idle(1);
		chk({31'h0, txd_out}, 32'h1);
		idle(12 * BIT);
		i_ufc_remote.got_q.delete();
		// Halt and suspend drop request-to-send, then time out
		for (int i = 0; i < 2; i++) begin
			wr(ufc_pkg::OFF_BEGIN_RX, 32'h1);
			wr(ufc_pkg::OFF_EV_RECEIVER_TIMEOUT_EVENT, 32'h0);
			chk({31'h0, rts_n_out}, 32'h0);
			wr(i ? ufc_pkg::OFF_SUSPEND : ufc_pkg::OFF_HALT_RX, 32'h1);
			idle(1);
			chk({31'h0, rts_n_out}, 32'h1);
			wait_ev(ufc_pkg::OFF_EV_RECEIVER_TIMEOUT_EVENT);
		end
		// Ninth bit on receive: good parity passes, bad parity flagged
		wr(ufc_pkg::OFF_CONFIG, 32'h3);
		i_ufc_remote.nbits = 9;
		wr(ufc_pkg::OFF_BEGIN_RX, 32'h1);
		for (int i = 0; i < 2; i++) begin
			b = 8'($random(seed));
			exp_q.push_back(b);
			i_ufc_remote.send({^b ^ i[0], b}, 1'b1);
			rx_get();
			rd(ufc_pkg::OFF_ERRSRC);
			chk(rdata, {30'h0, i[0], 1'b0});
		end
		wr(ufc_pkg::OFF_CONFIG, 32'h1);
		wr(ufc_pkg::OFF_ERRSRC, 32'hf);
		i_ufc_remote.nbits = 8;
		// Missing stop bit, then the line stays low into a break
		wr(ufc_pkg::OFF_BEGIN_RX, 32'h1);
		i_ufc_remote.send(9'h081, 1'b0);
		rd(ufc_pkg::OFF_ERRSRC);
		chk(rdata, 32'h4);
		idle(13 * BIT);
		rd(ufc_pkg::OFF_ERRSRC);
		chk(rdata, 32'hc);
		i_ufc_remote.rxd_in <= 1'b1;
		wait_ev(ufc_pkg::OFF_EV_ERROR);
		complete_run();
	end
endmodule

// ---- tb/ufc_remote.sv ----
// Far-side serial port model: sender, decoder and handshake lines
`timescale 1ns/10ps
module ufc_remote #(
	parameter int BIT = 8
) (
	input wire logic pclk,
	input wire logic txd_out,
	input wire logic rts_n_out,
	output logic rxd_in,
	output logic cts_n_in
);
	int nbits = 8;
	logic obey_rts = 1'b1;
	logic [8:0] got_q[$];
	// ==========================================
	// Idle line high, clear to send
	initial begin
		rxd_in = 1'b1;
		cts_n_in = 1'b0;
	end
	// Decode each frame at bit centres
	initial begin
		logic [8:0] v;
		forever begin
			@(negedge txd_out);
			repeat (BIT / 2) @(posedge pclk);
			v = 9'h000;
			for (int i = 0; i < nbits; i++) begin
				repeat (BIT) @(posedge pclk);
				v[i] = txd_out;
			end
			repeat (BIT) @(posedge pclk);
			got_q.push_back(v);
		end
	end
	// One frame out; a low stop bit leaves the line low
	task automatic send(input logic [8:0] v, input logic stop_bit);
		logic [10:0] f;
		f = (nbits == 9) ? {stop_bit, v, 1'b0} : {1'b1, stop_bit, v[7:0], 1'b0};
		while (obey_rts && rts_n_out) begin
			@(posedge pclk);
		end
		for (int i = 0; i < nbits + 2; i++) begin
			rxd_in <= f[i];
			repeat (BIT) @(posedge pclk);
		end
	endtask
endmodule
